/* cmm_pkg.sv */
// Address-map constants and carrier types for the core memory map unit
package cmm_pkg;
    localparam int PROG_AW = 22;
    localparam int DATA_AW = 32;
    localparam int WORD_W  = 16;
    localparam int VEC_IW  = 6;
    localparam int IO_AW   = 16;
    localparam int GLB_AW  = 15;
    localparam int SP_W    = 16;
    localparam int SRAM_AW = 11;

    localparam logic [PROG_AW-1:0] VEC_HI_BASE  = 22'h3F_FFC0;
    localparam logic [PROG_AW-1:0] VEC_LO_BASE  = 22'h00_0000;
    localparam int                 LEG_FORCE_LO = 16;
    localparam logic [PROG_AW-1:0] LEG_FORCE_MSK = 22'h3F_0000;

    localparam logic [DATA_AW-1:0] SRAM_SECOND_BASE = 32'h0000_0400;
    localparam logic [DATA_AW-1:0] SRAM_END         = 32'h0000_0800;
    localparam logic [DATA_AW-1:0] LBZ_LO           = 32'h0000_0200;
    localparam logic [DATA_AW-1:0] LBZ_HI           = 32'h0000_02FF;
    localparam logic [DATA_AW-1:0] RSV_LO           = 32'h0000_0800;
    localparam logic [DATA_AW-1:0] RSV_HI           = 32'h0000_09FF;

    localparam logic [SP_W-1:0] SP_RESET      = 16'h0400;
    localparam logic [SP_W-1:0] SP_STEP       = 16'h0001;
    localparam logic            VECTOR_MAP_SELECT_RESET    = 1'b1;
    localparam logic            OBJECT_MODE_SELECT_RESET = 1'b0;
    localparam logic            AMODE_RESET   = 1'b0;

    // Status bits that firmware may rewrite
    typedef struct packed {
        logic vectorMapSelect;
        logic objectModeSelect;
        logic addrModeLegacy;
    } cmm_status_t;

    // Program memory request from the fetch unit
    typedef struct packed {
        logic               valid;
        logic               legacy;
        logic [PROG_AW-1:0] addr;
    } cmm_prog_req_t;

    // Data memory request
    typedef struct packed {
        logic               valid;
        logic               write;
        logic [DATA_AW-1:0] addr;
        logic [WORD_W-1:0]  wdata;
    } cmm_data_req_t;

    // Port instruction request to the I/O space
    typedef struct packed {
        logic             valid;
        logic             write;
        logic [IO_AW-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } cmm_io_req_t;
endpackage

/* cmm_sram.sv */
// Single-access on-chip SRAM holding both internal blocks
`timescale 1ns/1ps
module cmm_sram #(
    parameter int AW = 11,
    parameter int DW = 16
) (
    input  wire logic          clk,
    input  wire logic          en,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // One access per cycle; read data registered
    always_ff @(posedge clk)
    begin
        if (en && we)
        begin
            mem[addr] <= wdata;
        end
        if (en && !we)
        begin
            rdata <= mem[addr];
        end
    end
endmodule

/* cmm_map.sv */
// Address-map unit: vectors, program forcing, data decode, stack pointer
//
// Contract
// - Vector table taken from one of two ranges per vector-map select.
// - Select one: vectors fetched from 0x3FFFC0 through 0x3FFFFF.
// - Select zero: vectors fetched from 0x000000 through 0x00003F.
// - Program space is 4M words on 22 address bits.
// - Data space is 4G words on 32 address bits.
// - Legacy instructions force upper program address bits to ones.
// - Two 1K-word single-access SRAM blocks, second at 0x0400.
// - Legacy block zero sits at 200h-2FFh in first block, unmirrored.
// - No legacy block-config bit; block zero never enters program space.
// - 64K I/O space reached only by port instructions.
// - 32K global space provided; global and I/O may be absent.
// - Stack pointer resets to 0x0400 and grows upward on push.
// - Core leaves reset in older object-compatible mode.
// - Vector-map status bit selects vector range unless VECTOR_MAP_SELECT_PIN_EN hands it to the pin; resets to one.
// - Object mode bit: 0 older object mode, 1 native; resets 0.
// - Addressing mode bit: 0 native, 1 legacy-compatible.
`timescale 1ns/1ps
module cmm_map #(
    parameter bit VECTOR_MAP_SELECT_PIN_EN = 1'b0,
    parameter bit IO_EN       = 1'b1,
    parameter bit GLOBAL_EN   = 1'b1
) (
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    input  wire logic                       vectorMapPin,
    input  wire logic                       statusWrite,
    input  wire cmm_pkg::cmm_status_t       statusWdata,
    input  wire logic                       vectorFetch,
    input  wire logic [cmm_pkg::VEC_IW-1:0] vectorIndex,
    input  wire cmm_pkg::cmm_prog_req_t     progReq,
    input  wire cmm_pkg::cmm_data_req_t     dataReq,
    input  wire cmm_pkg::cmm_io_req_t       ioReq,
    input  wire logic                       globalReq,
    input  wire logic [cmm_pkg::GLB_AW-1:0] globalAddr,
    input  wire logic                       spPush,
    input  wire logic                       spPop,
    output cmm_pkg::cmm_status_t            status,
    output logic                            vectorMapEff,
    output logic                            progValid,
    output logic [cmm_pkg::PROG_AW-1:0]     progAddr,
    output logic                            sramRvalid,
    output logic [cmm_pkg::WORD_W-1:0]      sramRdata,
    output logic                            extValid,
    output logic                            extWrite,
    output logic [cmm_pkg::DATA_AW-1:0]     extAddr,
    output logic [cmm_pkg::WORD_W-1:0]      extWdata,
    output logic                            legacyBlockZeroHit,
    output logic                            reservedHit,
    output cmm_pkg::cmm_io_req_t            ioBus,
    output logic                            ioRefused,
    output logic                            globalValid,
    output logic [cmm_pkg::GLB_AW-1:0]      globalBusAddr,
    output logic                            globalRefused,
    output logic [cmm_pkg::SP_W-1:0]        stackPtr
);
    // Pin synchroniser; stage one feeds stage two only
    logic pinMeta;
    logic pinSync;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pinMeta <= cmm_pkg::VECTOR_MAP_SELECT_RESET;
            pinSync <= cmm_pkg::VECTOR_MAP_SELECT_RESET;
        end
        else
        begin
            pinMeta <= vectorMapPin;
            pinSync <= pinMeta;
        end
    end

    // Status bits; there is deliberately no block-config bit to write
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            status.vectorMapSelect  <= cmm_pkg::VECTOR_MAP_SELECT_RESET;
            status.objectModeSelect <= cmm_pkg::OBJECT_MODE_SELECT_RESET;
            status.addrModeLegacy   <= cmm_pkg::AMODE_RESET;
        end
        else if (statusWrite)
        begin
            status <= statusWdata;
        end
    end

    // Where the pin is not brought out, the status bit alone decides
    logic next_vectorMap;
    assign next_vectorMap = VECTOR_MAP_SELECT_PIN_EN ? pinSync
                                        : status.vectorMapSelect;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            vectorMapEff <= cmm_pkg::VECTOR_MAP_SELECT_RESET;
        end
        else
        begin
            vectorMapEff <= next_vectorMap;
        end
    end

    // Vector address: base of the chosen range plus entry index
    logic [cmm_pkg::PROG_AW-1:0] vecBase;
    logic [cmm_pkg::PROG_AW-1:0] vecAddr;
    assign vecBase = next_vectorMap ? cmm_pkg::VEC_HI_BASE
                                    : cmm_pkg::VEC_LO_BASE;
    assign vecAddr = vecBase
                   | {{(cmm_pkg::PROG_AW-cmm_pkg::VEC_IW){1'b0}},
                      vectorIndex};

    // Forcing only on legacy instruction fetches; native passes whole
    logic [cmm_pkg::PROG_AW-1:0] forcedAddr;
    logic [cmm_pkg::PROG_AW-1:0] next_progAddr;
    logic                        next_progValid;
    assign forcedAddr = progReq.legacy
                      ? (progReq.addr | cmm_pkg::LEG_FORCE_MSK)
                      : progReq.addr;
    // A vector fetch takes priority over an ordinary fetch
    assign next_progAddr  = vectorFetch ? vecAddr : forcedAddr;
    assign next_progValid = vectorFetch | progReq.valid;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            progValid <= 1'b0;
            progAddr  <= '0;
        end
        else
        begin
            progValid <= next_progValid;
            progAddr  <= next_progAddr;
        end
    end

    // Data decode: low 2K words are internal, the rest goes outside
    logic inSram;
    logic inLbz;
    logic inRsv;
    logic sramEn;
    logic extGo;
    assign inSram = dataReq.addr < cmm_pkg::SRAM_END;
    // Block zero decoded only at its true range, no mirror copies
    assign inLbz  = status.addrModeLegacy
                  && dataReq.addr >= cmm_pkg::LBZ_LO
                  && dataReq.addr <= cmm_pkg::LBZ_HI;
    assign inRsv  = dataReq.addr >= cmm_pkg::RSV_LO
                  && dataReq.addr <= cmm_pkg::RSV_HI;
    assign sramEn = dataReq.valid && inSram;
    // Ordinary data accesses never reach the I/O bus
    assign extGo  = dataReq.valid && !inSram;

    logic [cmm_pkg::SRAM_AW-1:0] sramAddr;
    logic [cmm_pkg::WORD_W-1:0]  sramQ;
    assign sramAddr = dataReq.addr[cmm_pkg::SRAM_AW-1:0];

    // Both 1K blocks share one array; second block starts at 0x0400
    cmm_sram #(
        .AW (cmm_pkg::SRAM_AW),
        .DW (cmm_pkg::WORD_W)
    ) u_sram (
        .clk   (clk),
        .en    (sramEn),
        .we    (dataReq.write),
        .addr  (sramAddr),
        .wdata (dataReq.wdata),
        .rdata (sramQ)
    );

    // Read valid one cycle after the request; sramRdata carries the data a cycle later
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sramRvalid <= 1'b0;
        end
        else
        begin
            sramRvalid <= sramEn && !dataReq.write;
        end
    end

    // Registered copy keeps the output straight from a flip-flop
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sramRdata <= '0;
        end
        else if (sramRvalid)
        begin
            sramRdata <= sramQ;
        end
    end

    // External data request and decode flags
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            extValid           <= 1'b0;
            extWrite           <= 1'b0;
            extAddr            <= '0;
            extWdata           <= '0;
            legacyBlockZeroHit <= 1'b0;
            reservedHit        <= 1'b0;
        end
        else
        begin
            extValid           <= extGo;
            extWrite           <= dataReq.write;
            extAddr            <= dataReq.addr;
            extWdata           <= dataReq.wdata;
            legacyBlockZeroHit <= dataReq.valid && inLbz;
            reservedHit        <= dataReq.valid && inRsv;
        end
    end

    // I/O space only through the port request; refused when absent
    logic ioGo;
    assign ioGo = ioReq.valid && IO_EN;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ioBus     <= '0;
            ioRefused <= 1'b0;
        end
        else
        begin
            ioBus       <= ioReq;
            ioBus.valid <= ioGo;
            ioRefused   <= ioReq.valid && !IO_EN;
        end
    end

    // Global space, optional per part
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            globalValid   <= 1'b0;
            globalBusAddr <= '0;
            globalRefused <= 1'b0;
        end
        else
        begin
            globalValid   <= globalReq && GLOBAL_EN;
            globalBusAddr <= globalAddr;
            globalRefused <= globalReq && !GLOBAL_EN;
        end
    end

    // Stack pointer; push and pop together cancel out
    logic [cmm_pkg::SP_W-1:0] next_stackPtr;
    assign next_stackPtr = (spPush && !spPop)
                         ? stackPtr + cmm_pkg::SP_STEP
                         : (spPop && !spPush)
                         ? stackPtr - cmm_pkg::SP_STEP
                         : stackPtr;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stackPtr <= cmm_pkg::SP_RESET;
        end
        else
        begin
            stackPtr <= next_stackPtr;
        end
    end
endmodule

/* cmm_map_sva.sv */
// Property checker for the address-map unit, bound to its ports
`timescale 1ns/1ps
module cmm_map_sva (
    input wire logic                   clk,
    input wire logic                   sys_rst,
    input wire cmm_pkg::cmm_status_t   status,
    input wire cmm_pkg::cmm_status_t   statusWdata,
    input wire logic                   statusWrite,
    input wire logic                   vectorFetch,
    input wire logic [5:0]             vectorIndex,
    input wire cmm_pkg::cmm_prog_req_t progReq,
    input wire cmm_pkg::cmm_data_req_t dataReq,
    input wire cmm_pkg::cmm_io_req_t   ioReq,
    input wire cmm_pkg::cmm_io_req_t   ioBus,
    input wire logic                   spPush,
    input wire logic                   spPop,
    input wire logic                   progValid,
    input wire logic [21:0]            progAddr,
    input wire logic                   extValid,
    input wire logic [31:0]            extAddr,
    input wire logic                   legacyBlockZeroHit,
    input wire logic                   reservedHit,
    input wire logic [15:0]            stackPtr
);
    // Address windows of the incoming data request
    wire inSram = dataReq.valid && dataReq.addr < 32'h0000_0800;
    wire inLbz  = inSram && dataReq.addr[11:8] == 4'h2;
    wire inRsv  = dataReq.valid && dataReq.addr[31:9] == 23'h00_0004;
    wire natReq = progReq.valid && !vectorFetch;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_reset_state: assert property ($fell(sys_rst) |->
        status == 3'b100 && stackPtr == 16'h0400)
        else $error("state after reset wrong");
    a_vec_high: assert property (
        vectorFetch && status.vectorMapSelect |=>
        progValid && progAddr == {16'hFFFF, $past(vectorIndex)})
        else $error("vector not in high table");
    a_vec_low: assert property (
        vectorFetch && !status.vectorMapSelect |=>
        progValid && progAddr == {16'h0000, $past(vectorIndex)})
        else $error("vector not in low table");
    a_legacy_force: assert property (natReq && progReq.legacy |=>
        progAddr == {6'h3F, $past(progReq.addr[15:0])})
        else $error("legacy upper bits not forced");
    a_native_pass: assert property (natReq && !progReq.legacy |=>
        progValid && progAddr == $past(progReq.addr))
        else $error("native address altered");
    a_sram_local: assert property (inSram |=> !extValid)
        else $error("on-chip access leaked outside");
    a_lbz_flag: assert property (
        inLbz && status.addrModeLegacy |=> legacyBlockZeroHit)
        else $error("block zero access not flagged");
    a_rsv_flag: assert property (inRsv |=> reservedHit && extValid
        && extAddr == $past(dataReq.addr))
        else $error("reserved access not flagged");
    a_io_cause: assert property (ioBus.valid |-> $past(ioReq.valid))
        else $error("port bus without port request");
    a_status_load: assert property (
        statusWrite |=> status == $past(statusWdata))
        else $error("status not loaded");
    a_stack_return: assert property (
        spPush && !spPop ##1 spPop && !spPush |=>
        stackPtr == $past(stackPtr, 2))
        else $error("push then pop did not restore");
endmodule

bind cmm_map cmm_map_sva chk (.clk, .sys_rst, .status, .statusWdata,
    .statusWrite, .vectorFetch, .vectorIndex, .progReq, .dataReq, .ioReq,
    .ioBus, .spPush, .spPop, .progValid, .progAddr, .extValid, .extAddr,
    .legacyBlockZeroHit, .reservedHit, .stackPtr);

/* cmm_far_model.sv */
// Behavioural far side: external data memory and port registers
`timescale 1ns/1ps
module cmm_far_model (
    input  wire logic                 clk,
    input  wire logic                 extValid,
    input  wire logic                 extWrite,
    input  wire logic [31:0]          extAddr,
    input  wire logic [15:0]          extWdata,
    input  wire cmm_pkg::cmm_io_req_t ioBus,
    output logic      [15:0]          lastExtData,
    output logic      [15:0]          lastIoData,
    output logic                      strayWrite
);
    // Nothing is decoded in the reserved window, so writes there are noted
    always @(posedge clk)
    begin
        if (extValid && extWrite && extAddr[31:9] == 23'h00_0004)
            strayWrite <= 1'b1;
        else if (extValid && extWrite)
            lastExtData <= extWdata;
        if (ioBus.valid && ioBus.write)
            lastIoData <= ioBus.wdata;
    end
endmodule

/* cmm_map_bench.sv */
// Self-checking bench for the address-map unit
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        totalChecks++; \
        if ((g) !== (e)) \
        begin \
            miscompares++; \
            $display("unexpected at %0t: got %h exp %h", $time, g, e); \
        end \
    end
module cmm_map_bench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic statusWrite, vectorFetch, globalReq, spPush, spPop, stray;
    logic vectorMapEff, progValid, sramRvalid, extValid, extWrite;
    logic legacyBlockZeroHit, reservedHit, ioRefused, globalValid;
    logic globalRefused;
    cmm_pkg::cmm_status_t   status, statusWdata;
    cmm_pkg::cmm_prog_req_t progReq;
    cmm_pkg::cmm_data_req_t dataReq;
    cmm_pkg::cmm_io_req_t   ioReq, ioBus;
    logic [5:0]  vectorIndex;
    logic [14:0] globalAddr, globalBusAddr;
    logic [21:0] progAddr;
    logic [31:0] extAddr;
    logic [15:0] sramRdata, extWdata, stackPtr, lastExt, lastIo;
    int miscompares = 0;
    int totalChecks = 0;
    int cycles = 0;

    cmm_map dut (.clk, .sys_rst, .vectorMapPin(1'b0), .statusWrite,
        .statusWdata, .vectorFetch, .vectorIndex, .progReq, .dataReq,
        .ioReq, .globalReq, .globalAddr, .spPush, .spPop, .status,
        .vectorMapEff, .progValid, .progAddr, .sramRvalid, .sramRdata,
        .extValid, .extWrite, .extAddr, .extWdata, .legacyBlockZeroHit,
        .reservedHit, .ioBus, .ioRefused, .globalValid, .globalBusAddr,
        .globalRefused, .stackPtr);
    cmm_far_model far (.clk, .extValid, .extWrite, .extAddr, .extWdata,
        .ioBus, .lastExtData(lastExt), .lastIoData(lastIo),
        .strayWrite(stray));

    always #20 clk = ~clk;

    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            stopTest();
        end
    end

    task stopTest;
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Each helper holds its request one cycle and returns in the answer
    task vecOp(input logic [5:0] i);
        @(posedge clk);
        vectorFetch <= 1'b1;
        vectorIndex <= i;
        @(posedge clk);
        vectorFetch <= 1'b0;
        #1;
    endtask

    task progOp(input logic l, input logic [21:0] a);
        @(posedge clk);
        progReq <= '{1'b1, l, a};
        @(posedge clk);
        progReq.valid <= 1'b0;
        #1;
    endtask

    task dataOp(input logic w, input logic [31:0] a, input logic [15:0] d);
        @(posedge clk);
        dataReq <= '{1'b1, w, a, d};
        @(posedge clk);
        dataReq.valid <= 1'b0;
        #1;
    endtask

    task statusOp(input logic [2:0] s);
        @(posedge clk);
        statusWrite <= 1'b1;
        statusWdata <= s;
        @(posedge clk);
        statusWrite <= 1'b0;
        #1;
    endtask

    task settle;
        @(posedge clk);
        #1;
    endtask

    task testVectors;
        vecOp(6'h00);
        `CHK(progAddr, 22'h3F_FFC0)
        `CHK(progValid, 1'b1)
        vecOp(6'h3F);
        `CHK(progAddr, 22'h3F_FFFF)
        statusOp(3'b000);
        settle();
        `CHK(vectorMapEff, 1'b0)
        vecOp(6'h3F);
        `CHK(progAddr, 22'h00_003F)
    endtask

    task testProgram;
        progOp(1'b1, 22'h00_1234);
        `CHK(progAddr, 22'h3F_1234)
        progOp(1'b1, 22'h2A_5678);
        `CHK(progAddr, 22'h3F_5678)
        progOp(1'b0, 22'h2A_5678);
        `CHK(progAddr, 22'h2A_5678)
        progOp(1'b0, 22'h3F_FFFF);
        `CHK(progAddr, 22'h3F_FFFF)
    endtask

    task testSram;
        // Native addressing: block zero range is plain memory, no flag
        dataOp(1'b1, 32'h0000_0205, 16'h0000);
        `CHK(legacyBlockZeroHit, 1'b0)
        statusOp(3'b011);
        `CHK(status, 3'b011)
        // Old program-space copy of block zero stays ordinary program
        progOp(1'b1, 22'h00_FF00);
        `CHK(progAddr, 22'h3F_FF00)
        `CHK(legacyBlockZeroHit, 1'b0)
        dataOp(1'b1, 32'h0000_0405, 16'hA5A5);
        `CHK(extValid, 1'b0)
        dataOp(1'b1, 32'h0000_0105, 16'h1111);
        dataOp(1'b1, 32'h0000_0205, 16'h2222);
        `CHK(legacyBlockZeroHit, 1'b1)
        dataOp(1'b0, 32'h0000_0105, 16'h0000);
        settle();
        `CHK(sramRdata, 16'h1111)
        dataOp(1'b0, 32'h0000_0405, 16'h0000);
        `CHK(sramRvalid, 1'b1)
        settle();
        `CHK(sramRdata, 16'hA5A5)
    endtask

    task testOutside;
        dataOp(1'b1, 32'h0000_0900, 16'h5A5A);
        `CHK(reservedHit, 1'b1)
        `CHK(ioBus.valid, 1'b0)
        settle();
        `CHK(stray, 1'b1)
        dataOp(1'b1, 32'hFFFF_FFFF, 16'h3C3C);
        `CHK(extAddr, 32'hFFFF_FFFF)
        `CHK(extWrite, 1'b1)
        `CHK(extWdata, 16'h3C3C)
        settle();
        `CHK(lastExt, 16'h3C3C)
        @(posedge clk);
        ioReq <= '{1'b1, 1'b1, 16'hFFFF, 16'h7777};
        globalReq <= 1'b1;
        globalAddr <= 15'h7FFF;
        @(posedge clk);
        ioReq.valid <= 1'b0;
        globalReq <= 1'b0;
        #1;
        `CHK(ioBus.addr, 16'hFFFF)
        `CHK(globalBusAddr, 15'h7FFF)
        `CHK(ioBus.valid, 1'b1)
        `CHK(ioRefused, 1'b0)
        `CHK(globalValid, 1'b1)
        `CHK(globalRefused, 1'b0)
        settle();
        `CHK(lastIo, 16'h7777)
    endtask

    task testStack;
        @(posedge clk);
        spPush <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        spPush <= 1'b0;
        spPop <= 1'b1;
        #1;
        `CHK(stackPtr, 16'h0402)
        @(posedge clk);
        spPop <= 1'b0;
        #1;
        `CHK(stackPtr, 16'h0401)
    endtask

    // Inputs quiet from time zero; reset held ten cycles
    initial
    begin
        {statusWrite, vectorFetch, globalReq, spPush, spPop} = 5'h00;
        statusWdata = 3'b000;
        vectorIndex = 6'h00;
        globalAddr = 15'h0000;
        progReq = '0;
        dataReq = '0;
        ioReq = '0;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        settle();
        `CHK(status, 3'b100)
        `CHK(stackPtr, 16'h0400)
        testVectors();
        testProgram();
        testSram();
        testOutside();
        testStack();
        // One more edge so the push-pop property gets its last sample
        settle();
        stopTest();
    end
endmodule
